// ===== hw/lbv_pkg.sv
// Shared constants, types and register map for the break flag and vectors
`default_nettype none

package lbv_pkg;

  // Register port geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_GCR0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_GCR1 = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_INT_ENA = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_INT_LVL = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_VECT0 = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_VECT1 = 8'h24;

  // Field positions
  localparam int unsigned BIT_MODULE_RUN = 0;
  localparam int unsigned BIT_LIN_MODE = 6;
  localparam int unsigned BIT_SOFT_RESET = 7;
  localparam int unsigned BIT_BRK = 0;
  localparam int unsigned BIT_TX = 8;
  localparam int unsigned BIT_RX = 9;

  // Values after reset
  localparam logic [DATA_W-1:0] GCR0_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] GCR1_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] INT_ENA_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] INT_LVL_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] FLAGS_RST = 32'h0000_0000;

  // Vector geometry: offset n names flag bit n-1, offset zero means none
  localparam int unsigned VECT_W = 5;
  localparam int unsigned NUM_VEC_FLAGS = 31;
  localparam logic [VECT_W-1:0] OFF_NONE = 5'h00;
  localparam logic [NUM_VEC_FLAGS-1:0] KEEP_MASK = 31'h0000_0300;

  // Break timing
  localparam int unsigned BREAK_BITS = 10;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned BIT_TIME_NS = 8680;
  localparam int unsigned BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    BRK_IDLE = 3'b001,
    BRK_COUNT = 3'b010,
    BRK_HIGH = 3'b100
  } lbv_brk_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } lbv_bus_t;

endpackage

`default_nettype wire

// ===== hw/lbv_vec_enc.sv
// Priority encoder turning pending flags into a five-bit vector offset
`timescale 1ns/1ps
`default_nettype none

module lbv_vec_enc import lbv_pkg::*; #(
  parameter int unsigned N = NUM_VEC_FLAGS
) (
  // Pending and routed flags, bit 0 has the highest priority
  input wire logic [N-1:0] pending,
  // Offset of the winner
  output logic [VECT_W-1:0] offset
);

  // Scan downward so that the lowest pending index is the last to write
  always_comb begin
    offset = OFF_NONE;
    for (int i = N - 1; i >= 0; i--) begin
      if (pending[i]) begin
        offset = VECT_W'(i + 1);
      end
    end
  end

endmodule // lbv_vec_enc

`default_nettype wire

// ===== hw/lbv_break_det.sv
// Break detector: ten bit times of low line after a framing error
`timescale 1ns/1ps
`default_nettype none

module lbv_break_det import lbv_pkg::*; #(
  parameter int unsigned BITC = BIT_CYCLES,
  parameter int unsigned NBITS = BREAK_BITS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control and line
  input wire logic enable,
  input wire logic rx_pin,
  input wire logic frame_err,
  // Event
  output logic brk_pulse
);

  localparam int unsigned DIV_W = $clog2(BITC + 1);

  lbv_brk_state_t state_q, state_d;
  logic [DIV_W-1:0] div_q;
  logic [3:0] cnt_q;
  logic tick;
  logic start;

  // Bit divider restarts on the framing error so ticks fall on bit edges
  assign tick = (div_q == DIV_W'(BITC - 1));
  assign start = (state_q == BRK_IDLE) && enable && frame_err && !rx_pin;
  assign brk_pulse = (state_q == BRK_COUNT) && enable && !rx_pin && tick &&
                     (cnt_q == 4'(NBITS - 1));

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      BRK_IDLE: begin
        if (start) begin
          state_d = BRK_COUNT;
        end
      end
      BRK_COUNT: begin
        if (!enable || rx_pin) begin
          state_d = BRK_IDLE;
        end else if (brk_pulse) begin
          state_d = BRK_HIGH;
        end
      end
      BRK_HIGH: begin
        // One break gives one event; wait for the line to rise again
        if (!enable || rx_pin) begin
          state_d = BRK_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= BRK_IDLE;
      div_q <= '0;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      div_q <= (start || tick) ? '0 : div_q + DIV_W'(1);
      if (start) begin
        cnt_q <= '0;
      end else if (tick && state_q == BRK_COUNT) begin
        cnt_q <= cnt_q + 4'd1;
      end
    end
  end

  // Helper: consecutive low cycles, saturating
  logic [15:0] low_run_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      low_run_q <= '0;
    end else if (rx_pin) begin
      low_run_q <= '0;
    end else if (low_run_q != 16'hFFFF) begin
      low_run_q <= low_run_q + 16'd1;
    end
  end

  property p_brk_low_long;
    @(posedge core_clk) disable iff (rst)
    brk_pulse |-> (32'(low_run_q) >= NBITS * BITC - 1);
  endproperty
  a_brk_low_long: assert property (p_brk_low_long)
    else $error("break flagged before ten low bit times");

  property p_brk_mode;
    @(posedge core_clk) disable iff (rst)
    !enable |=> (state_q == BRK_IDLE) && !brk_pulse;
  endproperty
  a_brk_mode: assert property (p_brk_mode)
    else $error("break detector active outside compatible mode");

endmodule // lbv_break_det

`default_nettype wire

// ===== hw/lbv_core.sv
// Break-detect flag, flag register and the two interrupt vector registers
//
// Operation
// - A break is flagged when the receive line stays low ten bit times after a framing error.
// - Break detection works only in plain serial mode, never in LIN mode.
// - A detected break with its interrupt enabled raises the error request.
// - Reading the break offset from either vector register clears the break flag.
// - Soft reset, module reset and system reset clear the break flag.
// - The break flag reads 1 when set, writing 1 clears it and writing 0 keeps it.
// - The line-zero vector register shows a five-bit offset in bits 4 to 0.
// - Vector bits 31 to 5 read as zero and ignore writes.
// - Each vector read moves the vector on to the next pending interrupt.
// - A vector read clears the flag that belongs to the offset it returned.
// - Receive and transmit flags stay set when their offsets are read.
// - A second vector register does the same for interrupt line one.
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module lbv_core import lbv_pkg::*; #(
  parameter int unsigned BITC = BIT_CYCLES,
  parameter int unsigned NBITS = BREAK_BITS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire lbv_bus_t bus_i,
  output logic [DATA_W-1:0] rdata,
  // Receive line and frame logic
  input wire logic serial_receive_pin,
  input wire logic frame_err,
  input wire logic [DATA_W-1:0] flag_set_in,
  // Interrupt requests
  output logic error_int_req,
  output logic interrupt_line_zero,
  output logic interrupt_line_one
);

  logic [DATA_W-1:0] gcr0_q, gcr1_q, int_ena_q, int_lvl_q;
  logic [DATA_W-1:0] flags_q, flags_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic [NUM_VEC_FLAGS-1:0] skip_q [2];
  logic [NUM_VEC_FLAGS-1:0] skip_d [2];
  logic [NUM_VEC_FLAGS-1:0] pend [2];
  logic [NUM_VEC_FLAGS-1:0] vec_clr [2];
  logic [VECT_W-1:0] vec [2];
  logic [1:0] vec_rd;

  // Address decode
  wire wr_gcr0 = bus_i.wr && (bus_i.addr == OFF_GCR0);
  wire wr_gcr1 = bus_i.wr && (bus_i.addr == OFF_GCR1);
  wire wr_ena = bus_i.wr && (bus_i.addr == OFF_INT_ENA);
  wire wr_lvl = bus_i.wr && (bus_i.addr == OFF_INT_LVL);
  wire wr_flags = bus_i.wr && (bus_i.addr == OFF_FLAGS);
  assign vec_rd[0] = bus_i.rd && (bus_i.addr == OFF_VECT0);
  assign vec_rd[1] = bus_i.rd && (bus_i.addr == OFF_VECT1);

  // Mode and reset controls
  wire module_run = gcr0_q[BIT_MODULE_RUN];
  wire lin_mode = gcr1_q[BIT_LIN_MODE];
  wire soft_clr = wr_gcr1 && bus_i.wdata[BIT_SOFT_RESET];
  wire compat_en = module_run && !lin_mode;
  wire brk_pulse;

  lbv_break_det #(
    .BITC(BITC),
    .NBITS(NBITS)
  ) u_brk (
    .core_clk(core_clk),
    .rst(rst),
    .enable(compat_en),
    .rx_pin(serial_receive_pin),
    .frame_err(frame_err),
    .brk_pulse(brk_pulse)
  );

  // Per-line vector: route, encode, clear or skip what was served
  for (genvar l = 0; l < 2; l++) begin : g_line
    wire [NUM_VEC_FLAGS-1:0] routed;
    wire [NUM_VEC_FLAGS-1:0] served;
    assign routed = (l == 1) ? int_lvl_q[NUM_VEC_FLAGS-1:0] :
                    ~int_lvl_q[NUM_VEC_FLAGS-1:0];
    assign pend[l] = flags_q[NUM_VEC_FLAGS-1:0] &
                     int_ena_q[NUM_VEC_FLAGS-1:0] & routed &
                     ~skip_q[l];

    lbv_vec_enc #(
      .N(NUM_VEC_FLAGS)
    ) u_enc (
      .pending(pend[l]),
      .offset(vec[l])
    );

    assign served = (vec_rd[l] && vec[l] != OFF_NONE) ?
                    (NUM_VEC_FLAGS'(1) << (vec[l] - VECT_W'(1))) : '0;
    assign vec_clr[l] = served & ~KEEP_MASK;
    // Kept flags are hidden from this line until they drop, so the vector
    // can still move on past them
    assign skip_d[l] = (skip_q[l] | (served & KEEP_MASK)) &
                       flags_d[NUM_VEC_FLAGS-1:0];

    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        skip_q[l] <= '0;
      end else begin
        skip_q[l] <= skip_d[l];
      end
    end
  end

  // Flag update: hardware set wins over software and vector clears,
  // but a module or soft reset clears everything
  wire [DATA_W-1:0] set_ev = {flag_set_in[DATA_W-1:1], brk_pulse};
  wire [DATA_W-1:0] w1c = wr_flags ? bus_i.wdata : '0;
  wire [DATA_W-1:0] rd_clr = {1'b0, vec_clr[0] | vec_clr[1]};
  wire hold_clear = !module_run || soft_clr;
  assign flags_d = hold_clear ? '0 :
                   ((flags_q & ~(w1c | rd_clr)) | set_ev);

  // Read mux; vector reads return the value before they advance it
  wire [DATA_W-1:0] vec0_word = {{(DATA_W-VECT_W){1'b0}}, vec[0]};
  wire [DATA_W-1:0] vec1_word = {{(DATA_W-VECT_W){1'b0}}, vec[1]};
  assign rdata_d = !bus_i.rd ? '0 :
                   (bus_i.addr == OFF_GCR0) ? gcr0_q :
                   (bus_i.addr == OFF_GCR1) ? gcr1_q :
                   (bus_i.addr == OFF_INT_ENA) ? int_ena_q :
                   (bus_i.addr == OFF_INT_LVL) ? int_lvl_q :
                   (bus_i.addr == OFF_FLAGS) ? flags_q :
                   vec_rd[0] ? vec0_word :
                   vec_rd[1] ? vec1_word : '0;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gcr0_q <= GCR0_RST;
      gcr1_q <= GCR1_RST;
      int_ena_q <= INT_ENA_RST;
      int_lvl_q <= INT_LVL_RST;
    end else begin
      if (wr_gcr0) begin
        gcr0_q <= bus_i.wdata;
      end
      if (wr_gcr1) begin
        gcr1_q <= bus_i.wdata;
      end
      if (wr_ena) begin
        int_ena_q <= bus_i.wdata;
      end
      if (wr_lvl) begin
        int_lvl_q <= bus_i.wdata;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flags_q <= FLAGS_RST;
      rdata_q <= '0;
    end else begin
      flags_q <= flags_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;
  assign error_int_req = flags_q[BIT_BRK] && int_ena_q[BIT_BRK];
  assign interrupt_line_zero = (vec[0] != OFF_NONE);
  assign interrupt_line_one = (vec[1] != OFF_NONE);

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  wire quiet_set = (flag_set_in[DATA_W-1:1] == '0) && !brk_pulse;

  sequence s_brk_ok;
    brk_pulse && !hold_clear;
  endsequence

  property p_brk_sets;
    s_brk_ok |=> flags_q[BIT_BRK];
  endproperty
  a_brk_sets: assert property (p_brk_sets)
    else $error("break event did not set the flag");

  property p_brk_irq;
    s_brk_ok ##0 int_ena_q[BIT_BRK] && !wr_ena |=> error_int_req;
  endproperty
  a_brk_irq: assert property (p_brk_irq)
    else $error("enabled break did not raise error request");

  property p_w1c;
    wr_flags && bus_i.wdata[BIT_BRK] && !brk_pulse |=> !flags_q[BIT_BRK];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("writing one did not clear break flag");

  property p_w0_keeps;
    wr_flags && !bus_i.wdata[BIT_BRK] && flags_q[BIT_BRK] && !hold_clear
    |=> flags_q[BIT_BRK];
  endproperty
  a_w0_keeps: assert property (p_w0_keeps)
    else $error("writing zero changed break flag");

  property p_vec_brk_clr;
    (vec_rd[0] && vec[0] == VECT_W'(BIT_BRK + 1) ||
     vec_rd[1] && vec[1] == VECT_W'(BIT_BRK + 1)) && !brk_pulse
    |=> !flags_q[BIT_BRK];
  endproperty
  a_vec_brk_clr: assert property (p_vec_brk_clr)
    else $error("vector read left break flag set");

  property p_soft_clr;
    soft_clr |=> (flags_q == '0) && !error_int_req;
  endproperty
  a_soft_clr: assert property (p_soft_clr)
    else $error("soft reset did not clear flags");

  property p_stopped;
    !module_run |=> !flags_q[BIT_BRK];
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("break flag set while module held in reset");

  sequence s_vec0_read;
    vec_rd[0] ##1 1'b1;
  endsequence

  property p_vec0_word;
    s_vec0_read |-> rdata_q == {{(DATA_W-VECT_W){1'b0}}, $past(vec[0])};
  endproperty
  a_vec0_word: assert property (p_vec0_word)
    else $error("line zero vector read returned wrong word");

  property p_vec1_word;
    vec_rd[1] |=> rdata_q[DATA_W-1:VECT_W] == '0 &&
                  rdata_q[VECT_W-1:0] == $past(vec[1]);
  endproperty
  a_vec1_word: assert property (p_vec1_word)
    else $error("line one vector read returned wrong word");

  property p_advance;
    vec_rd[0] && vec[0] != OFF_NONE && quiet_set && !wr_ena && !wr_lvl
    |=> vec[0] != $past(vec[0]);
  endproperty
  a_advance: assert property (p_advance)
    else $error("vector did not advance after read");

  property p_rx_kept;
    vec_rd[0] && vec[0] == VECT_W'(BIT_RX + 1) && !hold_clear && !wr_flags
    |=> flags_q[BIT_RX];
  endproperty
  a_rx_kept: assert property (p_rx_kept)
    else $error("receive flag cleared by vector read");

  property p_vec_routed;
    vec[0] != OFF_NONE |-> int_ena_q[vec[0] - VECT_W'(1)] &&
                           !int_lvl_q[vec[0] - VECT_W'(1)] &&
                           flags_q[vec[0] - VECT_W'(1)];
  endproperty
  a_vec_routed: assert property (p_vec_routed)
    else $error("line zero vector names an unrouted interrupt");

  property p_vec_none;
    (pend[1] == '0) |-> !interrupt_line_one && vec[1] == OFF_NONE;
  endproperty
  a_vec_none: assert property (p_vec_none)
    else $error("line one vector nonzero with nothing pending");

  property p_set_wins;
    wr_flags && bus_i.wdata[BIT_BRK] && brk_pulse && !hold_clear
    |=> flags_q[BIT_BRK];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("break event lost to a write-one clear");

  property p_tx_kept;
    vec_rd[1] && vec[1] == VECT_W'(BIT_TX + 1) && !hold_clear && !wr_flags
    |=> flags_q[BIT_TX];
  endproperty
  a_tx_kept: assert property (p_tx_kept)
    else $error("transmit flag cleared by vector read");

  property p_advance1;
    vec_rd[1] && vec[1] != OFF_NONE && quiet_set
    |=> vec[1] != $past(vec[1]);
  endproperty
  a_advance1: assert property (p_advance1)
    else $error("line one vector did not advance after read");

  property p_vec1_routed;
    vec[1] != OFF_NONE |-> int_ena_q[vec[1] - VECT_W'(1)] &&
                           int_lvl_q[vec[1] - VECT_W'(1)] &&
                           flags_q[vec[1] - VECT_W'(1)];
  endproperty
  a_vec1_routed: assert property (p_vec1_routed)
    else $error("line one vector names an unrouted interrupt");

  // The flag has no software set path, so LIN mode must keep it low
  property p_lin_no_brk;
    lin_mode && !flags_q[BIT_BRK] |=> !flags_q[BIT_BRK];
  endproperty
  a_lin_no_brk: assert property (p_lin_no_brk)
    else $error("break flag set in LIN mode");

  property p_brk_read_irq;
    vec_rd[0] && vec[0] == VECT_W'(BIT_BRK + 1) && !brk_pulse
    |=> !error_int_req;
  endproperty
  a_brk_read_irq: assert property (p_brk_read_irq)
    else $error("break request still raised after its vector read");

endmodule // lbv_core

`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench for the break flag and the two vector registers
`timescale 1ns/1ps
`default_nettype none

module tb import lbv_pkg::*;;
  // Short bit time keeps each break near forty cycles
  localparam int unsigned TB_BITC = 4;
  localparam int unsigned BRK_CYC = BREAK_BITS * TB_BITC;
  localparam logic [31:0] SET_MASK = 32'hFFFF_FFFE;

  logic core_clk;
  logic rst;
  lbv_bus_t bus;
  logic [DATA_W-1:0] rdata;
  logic rx;
  logic frame_err;
  logic [DATA_W-1:0] flag_set;
  logic err_req;
  logic line0;
  logic line1;
  int error_cnt;
  int cmp_count;
  int cyc;
  logic [31:0] seed;
  logic [31:0] m_flags;
  logic [31:0] m_ena;
  logic [31:0] m_lvl;
  logic [31:0] hid0;
  logic [31:0] hid1;
  logic [31:0] got;
  logic [7:0] zero_offs [8];

  lbv_core #(.BITC(TB_BITC), .NBITS(BREAK_BITS)) dut (
    .core_clk(core_clk),
    .rst(rst),
    .bus_i(bus),
    .rdata(rdata),
    .serial_receive_pin(rx),
    .frame_err(frame_err),
    .flag_set_in(flag_set),
    .error_int_req(err_req),
    .interrupt_line_zero(line0),
    .interrupt_line_one(line1)
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic close_out();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // A hang is cut short well above the expected run of about two thousand cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  function automatic logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Lowest pending bit wins; offset is bit index plus one
  function automatic logic [4:0] exp_vec(input logic [31:0] f,
      input logic [31:0] en, input logic [31:0] rt, input logic [31:0] hd);
    logic [31:0] p;
    p = f & en & rt & ~hd;
    for (int i = 0; i < 31; i++) begin
      if (p[i]) return 5'(i + 1);
    end
    return 5'h00;
  endfunction

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic pulse_set(input logic [31:0] v);
    @(posedge core_clk);
    flag_set <= v;
    @(posedge core_clk);
    flag_set <= '0;
  endtask

  // Framing error with the line low; an abort lifts it for one cycle midway
  task automatic brk_run(input bit abort);
    @(posedge core_clk);
    rx <= 1'b0;
    frame_err <= 1'b1;
    @(posedge core_clk);
    frame_err <= 1'b0;
    repeat (BRK_CYC / 2) @(posedge core_clk);
    if (abort) begin
      rx <= 1'b1;
      @(posedge core_clk);
      rx <= 1'b0;
    end
    repeat (BRK_CYC) @(posedge core_clk);
    rx <= 1'b1;
    @(posedge core_clk);
    #1;
  endtask

  // Framing error, then the line low for len cycles only
  task automatic brk_cut(input int unsigned len);
    @(posedge core_clk);
    rx <= 1'b0;
    frame_err <= 1'b1;
    @(posedge core_clk);
    frame_err <= 1'b0;
    repeat (len) @(posedge core_clk);
    rx <= 1'b1;
    @(posedge core_clk);
  endtask

  task automatic chk_flags(input logic [31:0] e);
    bus_rd(OFF_FLAGS, got);
    chk_word(got, e);
  endtask

  task automatic vec_step(input bit ln);
    logic [4:0] e;
    e = exp_vec(m_flags, m_ena, ln ? m_lvl : ~m_lvl, ln ? hid1 : hid0);
    chk_bit(ln ? line1 : line0, e != 5'h00);
    bus_rd(ln ? OFF_VECT1 : OFF_VECT0, got);
    chk_word(got, {27'h0, e});
    if (e == 5'd9 || e == 5'd10) begin
      if (ln) hid1[e - 1] = 1'b1;
      else hid0[e - 1] = 1'b1;
    end else if (e != 5'h00) begin
      m_flags[e - 1] = 1'b0;
    end
  endtask

  initial begin
    seed = 32'd38668;
    rst = 1'b1;
    bus = '0;
    rx = 1'b1;
    frame_err = 1'b0;
    flag_set = '0;
    error_cnt = 0;
    cmp_count = 0;
    cyc = 0;
    zero_offs = '{OFF_GCR0, OFF_GCR1, OFF_INT_ENA, OFF_INT_LVL, OFF_FLAGS,
                  OFF_VECT0, OFF_VECT1, 8'hF0};
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    foreach (zero_offs[i]) begin
      bus_rd(zero_offs[i], got);
      chk_word(got, 32'h0000_0000);
    end
    bus_wr(OFF_VECT0, 32'hFFFF_FFFF);
    bus_wr(8'hF0, 32'hFFFF_FFFF);
    bus_rd(OFF_VECT0, got);
    chk_word(got, 32'h0000_0000);
    // Stopped module holds every flag low
    pulse_set(SET_MASK);
    chk_flags(32'h0000_0000);
    bus_wr(OFF_GCR0, 32'h0000_0001);
    bus_wr(OFF_INT_ENA, 32'h0000_0001);
    brk_run(0);
    chk_bit(err_req, 1'b1);
    chk_flags(32'h0000_0001);
    bus_wr(OFF_FLAGS, 32'h0000_0000);
    chk_flags(32'h0000_0001);
    bus_wr(OFF_FLAGS, 32'h0000_0001);
    chk_flags(32'h0000_0000);
    chk_bit(err_req, 1'b0);
    brk_run(1);
    chk_flags(32'h0000_0000);
    // Line rises one cycle short of ten bit times, then exactly on time
    brk_cut(BRK_CYC - 1);
    chk_flags(32'h0000_0000);
    brk_cut(BRK_CYC);
    chk_flags(32'h0000_0001);
    bus_wr(OFF_FLAGS, 32'h0000_0001);
    bus_wr(OFF_INT_ENA, 32'h0000_0000);
    brk_run(0);
    chk_bit(err_req, 1'b0);
    bus_rd(OFF_VECT0, got);
    chk_word(got, 32'h0000_0000);
    bus_wr(OFF_INT_ENA, 32'h0000_0001);
    bus_rd(OFF_VECT0, got);
    chk_word(got, 32'h0000_0001);
    chk_flags(32'h0000_0000);
    bus_wr(OFF_GCR1, 32'h0000_0040);
    brk_run(0);
    chk_flags(32'h0000_0000);
    bus_wr(OFF_GCR1, 32'h0000_0000);
    bus_wr(OFF_INT_LVL, 32'h0000_0001);
    brk_run(0);
    bus_rd(OFF_VECT0, got);
    chk_word(got, 32'h0000_0000);
    bus_rd(OFF_VECT1, got);
    chk_word(got, 32'h0000_0001);
    chk_flags(32'h0000_0000);
    brk_run(0);
    pulse_set(nxt() & SET_MASK);
    bus_wr(OFF_GCR1, 32'h0000_0080);
    chk_flags(32'h0000_0000);
    bus_wr(OFF_GCR1, 32'h0000_0000);
    brk_run(0);
    bus_wr(OFF_GCR0, 32'h0000_0000);
    bus_wr(OFF_GCR0, 32'h0000_0001);
    chk_flags(32'h0000_0000);
    // System reset in mid-run clears a pending break and its request
    brk_run(0);
    chk_bit(err_req, 1'b1);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    chk_flags(32'h0000_0000);
    chk_bit(err_req, 1'b0);
    bus_wr(OFF_GCR0, 32'h0000_0001);
    // First round routes everything to line zero with both kept flags set
    for (int r = 0; r < 8; r++) begin
      m_ena = (r == 0) ? 32'hFFFF_FFFF : nxt();
      m_lvl = (r == 0) ? 32'h0000_0000 : nxt();
      m_flags = (nxt() | 32'h0000_0300) & SET_MASK;
      hid0 = '0;
      hid1 = '0;
      bus_wr(OFF_INT_ENA, m_ena);
      bus_wr(OFF_INT_LVL, m_lvl);
      pulse_set(m_flags);
      chk_flags(m_flags);
      repeat (34) begin
        vec_step(1'b0);
        vec_step(1'b1);
      end
      chk_flags(m_flags);
      bus_wr(OFF_FLAGS, 32'hFFFF_FFFF);
      chk_flags(32'h0000_0000);
    end
    close_out();
  end
endmodule // tb

`default_nettype wire
